/* File: comm_fault_pkg.sv */
// Package: register map, encodings and carriers for the comm fault controller
package comm_fault_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_STORAGE = 4'h0;
    localparam logic [3:0] OFS_STOP_MODE = 4'h4;
    localparam logic [3:0] OFS_SUBST_FREQ = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // Reset values and the substitute frequency upper limit
    localparam logic STORAGE_RST = 1'b0;
    localparam logic [1:0] STOP_MODE_RST = 2'h0;
    localparam logic [13:0] SUBST_KEEP = 14'h270F;
    localparam logic [13:0] SUBST_MAX = 14'h0190;
    // Fault codes shown on the display
    localparam logic [7:0] SERIAL_COMM_FAULT_CODE = 8'hA0;
    localparam logic [7:0] OPTION_FAULT_CODE_A = 8'hA1;
    localparam logic [7:0] OPTION_FAULT_CODE_B = 8'hA2;
    localparam logic [7:0] NORMAL_CODE = 8'h00;
    // Output terminal function codes for the comm alarm
    localparam logic [7:0] ALARM_FUNC_POS = 8'h62;
    localparam logic [7:0] ALARM_FUNC_NEG = 8'hC6;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_COAST = 3'b001,
        ST_DECEL = 3'b010,
        ST_TRIPPED = 3'b011,
        ST_SUBST = 3'b100
    } react_state_t;

    // Parameter write request from the link
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } param_wr_t;

    // Commands handed to the ramp and output stage
    typedef struct packed {
        logic coast;
        logic decel_stop;
        logic hold_cmd;
        logic use_subst;
        logic [13:0] subst_freq;
    } ramp_cmd_t;
endpackage

/* File: comm_fault_response_ctrl.sv */
// Communication write storage and communication error reaction controller
`timescale 1ns/1ps
module comm_fault_response_ctrl
    import comm_fault_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Link side
    input wire param_wr_t link_wr,
    input wire logic link_retry_excess,
    input wire logic link_check_timeout,
    input wire logic link_is_option,
    input wire logic link_is_cmd_source,
    input wire logic option_code_b_sel,
    input wire logic retry_limit_off,
    input wire logic check_interval_off,
    input wire logic net_mode,
    // Ramp side
    input wire logic motor_stopped,
    input wire logic power_up_load,
    input wire logic [7:0] alarm_terminal_func,
    output ramp_cmd_t ramp_cmd,
    // Memory stores
    output param_wr_t nv_wr,
    output param_wr_t ram_wr,
    output logic nv_reload,
    // Indication and outputs
    output logic [7:0] display_code,
    output logic fault_output_signal,
    output logic alarm_bit,
    output logic comm_alarm_signal,
    output logic history_log,
    output logic history_temp,
    output logic history_restore
);

    // ----------------------------------------
    // Settings and bus slave
    // ----------------------------------------
    logic write_storage_select_r;
    logic [1:0] comm_error_stop_mode_r;
    logic [13:0] substitute_frequency_r;
    react_state_t state_r;
    react_state_t state_nxt;
    logic err_r;
    logic ack_r;

    // One wait cycle per access keeps the read mux off the critical path
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // Writes land at the acknowledging edge; bad values keep the last good one
    always_ff @(posedge clock) begin
        if (reset) begin
            write_storage_select_r <= STORAGE_RST;
            comm_error_stop_mode_r <= STOP_MODE_RST;
            substitute_frequency_r <= SUBST_KEEP;
        end else if (avs_write && ack_r) begin
            case (avs_address)
                OFS_STORAGE: begin
                    if (avs_writedata[31:1] == 31'h0) begin
                        write_storage_select_r <= avs_writedata[0];
                    end
                end
                OFS_STOP_MODE: begin
                    if (avs_writedata[31:2] == 30'h0) begin
                        comm_error_stop_mode_r <= avs_writedata[1:0];
                    end
                end
                OFS_SUBST_FREQ: begin
                    if (avs_writedata[31:14] == 18'h0 &&
                        (avs_writedata[13:0] <= SUBST_MAX ||
                         avs_writedata[13:0] == SUBST_KEEP)) begin
                        substitute_frequency_r <= avs_writedata[13:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                OFS_STORAGE: avs_readdata <= {31'h0, write_storage_select_r};
                OFS_STOP_MODE: avs_readdata <= {30'h0, comm_error_stop_mode_r};
                OFS_SUBST_FREQ: avs_readdata <= {18'h0,
                                                 substitute_frequency_r};
                OFS_STATUS: avs_readdata <= {27'h0, err_r, fault_output_signal,
                                             state_r};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // Parameter storage routing
    // ----------------------------------------
    // Setting 1 spares nonvolatile wear at the cost of losing values at power-off
    always_ff @(posedge clock) begin
        if (reset) begin
            nv_wr <= '0;
            ram_wr <= '0;
            nv_reload <= 1'b0;
        end else begin
            ram_wr <= link_wr;
            nv_wr <= link_wr;
            nv_wr.valid <= link_wr.valid & ~write_storage_select_r;
            nv_reload <= power_up_load;
        end
    end

    // ----------------------------------------
    // Error detection and reaction
    // ----------------------------------------
    logic err_now;
    logic err_fall;
    assign err_now = net_mode & link_is_cmd_source
                   & (link_retry_excess | link_check_timeout);
    assign err_fall = err_r & ~err_now;

    always_ff @(posedge clock) begin
        if (reset) begin
            err_r <= 1'b0;
        end else begin
            err_r <= err_now;
        end
    end

    // Reaction state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (err_now) begin
                    case (comm_error_stop_mode_r)
                        2'h0: state_nxt = ST_COAST;
                        2'h1, 2'h2: state_nxt = ST_DECEL;
                        default: begin
                            if (!(retry_limit_off && check_interval_off)) begin
                                state_nxt = ST_SUBST;
                            end
                        end
                    endcase
                end
            end
            ST_COAST: state_nxt = ST_TRIPPED;
            ST_DECEL: begin
                if (comm_error_stop_mode_r == 2'h2 && !err_now) begin
                    state_nxt = ST_NORMAL;
                end else if (motor_stopped) begin
                    // Mode 1 trips here; mode 2 shows the code only
                    state_nxt = ST_TRIPPED;
                end
            end
            ST_TRIPPED: begin
                if (comm_error_stop_mode_r == 2'h2 && !err_now) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_SUBST: begin
                if (!err_now) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: state_nxt = ST_NORMAL;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Outputs to ramp, display and history
    // ----------------------------------------
    logic faulted;
    logic temp_shown;
    logic [7:0] fault_code;
    assign faulted = (state_r == ST_COAST) || (state_r == ST_TRIPPED
                     && comm_error_stop_mode_r != 2'h2);
    // Mode 2 shows the code after stop without raising the fault output
    assign temp_shown = (state_r == ST_TRIPPED) && !faulted;
    assign fault_code = !link_is_option ? SERIAL_COMM_FAULT_CODE :
                        option_code_b_sel ? OPTION_FAULT_CODE_B :
                        OPTION_FAULT_CODE_A;

    always_ff @(posedge clock) begin
        if (reset) begin
            ramp_cmd <= '0;
            display_code <= NORMAL_CODE;
            fault_output_signal <= 1'b0;
            alarm_bit <= 1'b0;
            comm_alarm_signal <= 1'b0;
        end else begin
            // Normal ramp times apply; the ramp stage owns them
            ramp_cmd.coast <= (state_nxt == ST_COAST)
                            || (state_nxt == ST_TRIPPED
                                && comm_error_stop_mode_r == 2'h0);
            ramp_cmd.decel_stop <= (state_nxt == ST_DECEL)
                                 || (state_nxt == ST_TRIPPED
                                     && comm_error_stop_mode_r != 2'h0);
            ramp_cmd.hold_cmd <= (state_nxt == ST_SUBST)
                || (comm_error_stop_mode_r == 2'h2
                    && state_nxt != ST_NORMAL);
            ramp_cmd.use_subst <= (state_nxt == ST_SUBST)
                                && substitute_frequency_r != SUBST_KEEP;
            ramp_cmd.subst_freq <= substitute_frequency_r;
            display_code <= (faulted || temp_shown) ? fault_code : NORMAL_CODE;
            fault_output_signal <= faulted;
            alarm_bit <= faulted;
            comm_alarm_signal <= (state_r == ST_SUBST)
                ? (alarm_terminal_func == ALARM_FUNC_POS)
                : (alarm_terminal_func == ALARM_FUNC_NEG);
        end
    end

    // History: log on fault output rise, temporary entry when mode 2 shows the code
    logic faulted_d_r;
    logic temp_d_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            faulted_d_r <= 1'b0;
            temp_d_r <= 1'b0;
            history_log <= 1'b0;
            history_temp <= 1'b0;
            history_restore <= 1'b0;
        end else begin
            faulted_d_r <= faulted;
            temp_d_r <= temp_shown;
            history_log <= faulted & ~faulted_d_r;
            history_temp <= temp_shown & ~temp_d_r;
            history_restore <= ~temp_shown & temp_d_r;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // One clock domain, so every property shares this clock and reset
    default clocking assert_clk @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_err_rise;
        !err_r ##1 err_r;
    endsequence

    a_nv_gated: assert property (
        link_wr.valid && write_storage_select_r |=> !nv_wr.valid)
        else $error("nonvolatile write while in working-only mode");
    a_nv_both: assert property (
        link_wr.valid && !write_storage_select_r
        |=> nv_wr.valid && ram_wr.valid)
        else $error("link write not stored in both memories");
    a_mode0_fault: assert property (
        state_r == ST_NORMAL && err_now && comm_error_stop_mode_r == 2'h0
        |=> ##1 fault_output_signal)
        else $error("mode 0 fault output late");
    a_coast_first: assert property (
        state_r == ST_COAST |-> ramp_cmd.coast)
        else $error("coast state without coast command");
    a_mode0_stays: assert property (
        state_r == ST_TRIPPED && comm_error_stop_mode_r == 2'h0
        |=> state_r == ST_TRIPPED)
        else $error("mode 0 trip released");
    a_mode1_after: assert property (
        state_r == ST_DECEL |-> !fault_output_signal)
        else $error("fault output before stop");
    a_mode2_nofault: assert property (
        comm_error_stop_mode_r == 2'h2 && $stable(comm_error_stop_mode_r)
        ##1 $stable(comm_error_stop_mode_r) |-> !fault_output_signal)
        else $error("mode 2 asserted fault output");
    a_mode2_restart: assert property (
        comm_error_stop_mode_r == 2'h2 && state_r == ST_DECEL && !err_now
        |=> state_r == ST_NORMAL)
        else $error("mode 2 did not re-accelerate on clear");
    a_mode3_run: assert property (
        state_r == ST_SUBST |-> !faulted && display_code == NORMAL_CODE
        || $past(state_r) != ST_SUBST)
        else $error("mode 3 shows a fault");
    a_mode3_alarm: assert property (
        state_r == ST_SUBST && alarm_terminal_func == ALARM_FUNC_POS
        |=> comm_alarm_signal)
        else $error("comm alarm missing in substitute run");
    a_mode3_off: assert property (
        retry_limit_off && check_interval_off && state_r == ST_NORMAL
        |=> state_r != ST_SUBST)
        else $error("substitute run with detection off");
    a_trip_logged: assert property (
        $rose(fault_output_signal) |-> history_log)
        else $error("fault output raised without history record");
    a_net_only: assert property (
        !net_mode |=> !err_r)
        else $error("error latched outside network mode");
    // The latch must follow the qualified link inputs, not a stale copy
    a_err_latch: assert property (
        s_err_rise |-> $past(net_mode && link_is_cmd_source
            && (link_retry_excess || link_check_timeout)))
        else $error("error latch not from qualified link inputs");
endmodule

/* File: link_master_model.sv */
// Far-side link master model: parameter write frames and error sources
`timescale 1ns/1ps
module link_master_model
    import comm_fault_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic send,
    input wire logic [15:0] send_addr,
    input wire logic [15:0] send_data,
    input wire logic fail_retry,
    input wire logic fail_silent,
    output param_wr_t link_wr,
    output logic link_retry_excess,
    output logic link_check_timeout
);
    // One-cycle write frame; idle fields toggle so stale data never matches
    always_ff @(posedge clock) begin
        if (reset) begin
            link_wr <= '0;
        end else begin
            link_wr.valid <= send;
            link_wr.addr <= send ? send_addr : ~link_wr.addr;
            link_wr.data <= send ? send_data : ~link_wr.data;
        end
    end

    // Retry excess and silence timeout as held levels
    always_ff @(posedge clock) begin
        link_retry_excess <= fail_retry && !reset;
        link_check_timeout <= fail_silent && !reset;
    end
endmodule

/* File: comm_fault_response_ctrl_bench.sv */
// Bench for the comm fault response controller
`timescale 1ns/1ps
module comm_fault_response_ctrl_bench;
    import comm_fault_pkg::*;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    param_wr_t link_wr;
    param_wr_t nv_wr;
    param_wr_t ram_wr;
    ramp_cmd_t ramp_cmd;
    logic retry_x, timeout_x, nv_reload, fault_sig, alarm_bit, comm_alarm;
    logic is_opt = 1'h0, code_b = 1'h0, r_off = 1'h0, c_off = 1'h0;
    logic net = 1'h1, stopped = 1'h0, pwr = 1'h0, send = 1'h0;
    logic fail_r = 1'h0, fail_t = 1'h0;
    logic [7:0] func = 8'h62;
    logic [7:0] display_code;
    logic hist_log, hist_temp, hist_rest;
    logic src = 1'h1;
    int log_n = 0;
    int temp_n = 0;
    int rest_n = 0;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    comm_fault_response_ctrl i_comm_fault_response_ctrl (.clock(clock),
        .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link_wr(link_wr), .link_retry_excess(retry_x),
        .link_check_timeout(timeout_x), .link_is_option(is_opt),
        .link_is_cmd_source(src), .option_code_b_sel(code_b),
        .retry_limit_off(r_off), .check_interval_off(c_off),
        .net_mode(net), .motor_stopped(stopped), .power_up_load(pwr),
        .alarm_terminal_func(func), .ramp_cmd(ramp_cmd), .nv_wr(nv_wr),
        .ram_wr(ram_wr), .nv_reload(nv_reload), .display_code(display_code),
        .fault_output_signal(fault_sig), .alarm_bit(alarm_bit),
        .comm_alarm_signal(comm_alarm), .history_log(hist_log),
        .history_temp(hist_temp), .history_restore(hist_rest));

    link_master_model i_link_master_model (.clock(clock), .reset(reset),
        .send(send), .send_addr(16'h0010), .send_data(16'h1234),
        .fail_retry(fail_r), .fail_silent(fail_t), .link_wr(link_wr),
        .link_retry_excess(retry_x), .link_check_timeout(timeout_x));

    // ----------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------
    always #4 clock = ~clock;

    // A hang ends the run as a failure instead of running forever
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    // History outputs are one-cycle pulses, so count them as they pass
    always @(posedge clock) begin
        log_n <= log_n + int'(hist_log);
        temp_n <= temp_n + int'(hist_temp);
        rest_n <= rest_n + int'(hist_rest);
    end

    task automatic results();
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'h0)
            @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clock);
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rchk(input string n, input logic [3:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        check(n, q, e);
    endtask

    // Checks after this read values settled before the last edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic do_reset();
        @(posedge clock);
        reset <= 1'h1;
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
    endtask

    task automatic link_send();
        send <= 1'h1;
        @(posedge clock);
        send <= 1'h0;
        wait_n(2);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        rchk("storage reset", 4'h0, 32'h0);
        rchk("mode reset", 4'h4, 32'h0);
        rchk("freq reset", 4'h8, 32'h270F);
        rchk("unmapped", 4'h2, 32'h0);
        link_send();
        check("nv both", nv_wr.valid, 1'h1);
        check("nv word", {nv_wr.addr, nv_wr.data}, 32'h00101234);
        check("ram both", ram_wr.valid, 1'h1);
        check("ram word", {ram_wr.addr, ram_wr.data}, 32'h00101234);
        wreg(4'h0, 32'h1);
        wreg(4'h0, 32'h2);
        rchk("storage bad", 4'h0, 32'h1);
        link_send();
        check("nv only ram", nv_wr.valid, 1'h0);
        check("ram only", ram_wr.valid, 1'h1);
        pwr <= 1'h1;
        @(posedge clock);
        pwr <= 1'h0;
        @(posedge clock);
        check("reload", nv_reload, 1'h1);
        wreg(4'h4, 32'h5);
        rchk("mode bad", 4'h4, 32'h0);
        wreg(4'h8, 32'h191);
        rchk("freq bad", 4'h8, 32'h270F);
        // Outside network mode an error must not react
        net <= 1'h0;
        fail_r <= 1'h1;
        wait_n(4);
        check("no net", {fault_sig, ramp_cmd.coast}, 2'h0);
        net <= 1'h1;
        src <= 1'h0;
        wait_n(4);
        check("no source", {fault_sig, ramp_cmd.coast}, 2'h0);
        src <= 1'h1;
        wait_n(4);
        check("coast", ramp_cmd.coast, 1'h1);
        check("code serial", display_code, 8'hA0);
        fail_r <= 1'h0;
        wait_n(4);
        check("fault held", {fault_sig, alarm_bit}, 2'h3);
        check("fault logged", log_n, 1);
        rchk("status", 4'hC, 32'h0000000B);
        // Mode 1 over the option link, code B
        do_reset();
        wreg(4'h4, 32'h1);
        is_opt <= 1'h1;
        code_b <= 1'h1;
        fail_t <= 1'h1;
        wait_n(4);
        check("decel", {ramp_cmd.decel_stop, fault_sig}, 2'h2);
        stopped <= 1'h1;
        fail_t <= 1'h0;
        wait_n(4);
        check("fault stop", {fault_sig, alarm_bit}, 2'h3);
        check("code opt b", display_code, 8'hA2);
        check("fault logged 2", log_n, 2);
        // Mode 2: clear during decel, then stop with error held
        do_reset();
        is_opt <= 1'h0;
        stopped <= 1'h0;
        wreg(4'h4, 32'h2);
        fail_r <= 1'h1;
        wait_n(4);
        check("m2 decel", ramp_cmd.decel_stop, 1'h1);
        check("m2 hold", ramp_cmd.hold_cmd, 1'h1);
        fail_r <= 1'h0;
        wait_n(4);
        check("reaccel", {ramp_cmd.decel_stop, fault_sig}, 2'h0);
        fail_r <= 1'h1;
        stopped <= 1'h1;
        wait_n(5);
        check("m2 no fault", fault_sig, 1'h0);
        check("m2 code after stop", display_code, 8'hA0);
        fail_r <= 1'h0;
        wait_n(5);
        check("m2 normal", display_code, 8'h00);
        check("m2 temp record", temp_n, 1);
        check("m2 restored", rest_n, 1);
        check("m2 not logged", log_n, 2);
        // Mode 3 substitute run at the top of the range
        stopped <= 1'h0;
        wreg(4'h4, 32'h3);
        wreg(4'h8, 32'h190);
        fail_t <= 1'h1;
        wait_n(4);
        check("subst", ramp_cmd.use_subst, 1'h1);
        check("subst freq", ramp_cmd.subst_freq, 14'h0190);
        check("lf pos", {comm_alarm, fault_sig}, 2'h2);
        check("m3 ind", display_code, 8'h00);
        func <= 8'hC6;
        wait_n(3);
        check("lf neg", comm_alarm, 1'h0);
        fail_t <= 1'h0;
        wait_n(4);
        check("m3 back", ramp_cmd.use_subst, 1'h0);
        r_off <= 1'h1;
        c_off <= 1'h1;
        fail_t <= 1'h1;
        wait_n(4);
        check("m3 disabled", ramp_cmd.use_subst, 1'h0);
        results();
    end
endmodule
